//--- core/cma_top.sv
// Purpose: Table access, self-timed byte programming and read-only identification of configuration bytes.
// Assumes: Core strobes are one-cycle pulses synchronous to core_clk_in.
// Notes:   Contents return to unprogrammed values on reset.
// Functional notes
// [R1] Programmed cells read 0, unprogrammed cells read 1.
// [R2] Configuration bytes start at program address 300000h.
// [R3] Config space 300000h-3FFFFFh reached only by table read and table write.
// [R4] Write-start bit launches a self-timed programming cycle with no further stimulus.
// [R5] Core first issues a table write that loads address and data.
// [R6] One configuration byte is programmed per write cycle.
// [R7] A table write may place either one or zero in any cell; here unimplemented positions keep their unprogrammed value.
// [R8] Identification registers are read-only; program attempts leave them unchanged.
// [R9] Low-voltage programming enable accepts writes only in high-voltage programming mode.
// [R10] Configuration write-protect bit is read-only in user mode.
// [R11] Parts without dedicated debug port program its enable bit clear.
// [R12] Watchdog is hardware enabled by configuration or left under software control.
// [R13] Unprogrammed bytes return listed defaults; unimplemented positions read zero, except in byte 7 (300007h), which reads FFh.
// [R14] Identification holds five-bit revision and eleven-bit part code across two registers.
// [R15] Reading a byte under programming returns its previous contents.
module cma_top #(
  parameter int          PROG_CYCLES   = cma_pkg::PROG_CYCLES,
  parameter logic [4:0]  IDENT_REVISION = cma_pkg::IDENT_REVISION_DEFAULT,
  parameter logic [10:0] IDENT_PART     = cma_pkg::IDENT_PART_DEFAULT
) (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // Table access from the core
  input  wire logic [21:0] table_pointer_in,
  input  wire logic        table_read_instr_in,
  input  wire logic        table_write_instr_in,
  input  wire logic [7:0]  table_write_data_in,
  output logic      [7:0]  table_read_data_out,
  output logic             table_read_valid_out,
  // Nonvolatile control register
  input  wire logic        nv_write_start_in,
  output logic             nv_write_busy_out,
  output logic             nv_write_done_out,
  output logic             nv_write_rejected_out,
  // Ordinary fetch and data accesses
  input  wire logic        ordinary_access_in,
  input  wire logic [21:0] ordinary_addr_in,
  output logic             access_fault_out,
  // Mode
  input  wire logic        hv_prog_mode_in,
  // Configuration outputs
  output logic             watchdog_timer_hw_enable_out,
  output logic             watchdog_timer_sw_control_out,
  output logic             watchdog_timer_active_only_out,
  output logic             low_voltage_prog_enable_out,
  output logic             dedicated_debug_port_enable_out,
  output logic             config_write_protect_out
);

  localparam int N = cma_pkg::NUM_CFG_BYTES;

  typedef struct packed {
    logic       hit;
    logic       ident;
    logic [3:0] idx;
  } cma_decode_t;

  function automatic cma_decode_t cma_decode(input logic [21:0] addr);
    cma_decode_t d;
    logic [21:0] delta;
    d     = '0;
    delta = addr - cma_pkg::CFG_SPACE_BASE;
    if (addr >= cma_pkg::CFG_SPACE_BASE && delta < 22'(N)) begin
      d.hit = 1'b1; // [R2]
      d.idx = delta[3:0];
    end
    d.ident = (addr == cma_pkg::OFS_PART_REVISION_IDENT) || (addr == cma_pkg::OFS_PART_IDENT_HIGH);
    return d;
  endfunction

  // Cell array
  logic [7:0] cell_value [N];
  logic [N-1:0] commit_vec;
  logic [7:0] commit_data;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cell
      cma_cfg_byte #(
        .DEFAULT_VALUE (cma_pkg::CFG_DEFAULT[g]),
        .IMPL_MASK     (cma_pkg::CFG_IMPL_MASK[g])
      ) u_cell (
        .core_clk_in    (core_clk_in),
        .rst_in         (rst_in),
        .commit_in      (commit_vec[g]),   // [R6]
        .commit_data_in (commit_data),
        .value_out      (cell_value[g])   // [R1] [R13]
      );
    end
  endgenerate

  // Programming timer
  logic timer_start;
  logic timer_done;

  cma_prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .start_in    (timer_start),
    .busy_out    (),
    .done_out    (timer_done)
  );

  // Write sequence state
  cma_pkg::cma_state_t state_reg;
  cma_pkg::cma_state_t state_next;
  logic [21:0] lat_addr_reg;
  logic [21:0] lat_addr_next;
  logic [7:0]  lat_data_reg;
  logic [7:0]  lat_data_next;
  logic        busy_reg;
  logic        busy_next;
  logic        done_reg;
  logic        done_next;
  logic        reject_reg;
  logic        reject_next;

  cma_decode_t lat_dec;

  always_comb begin
    lat_dec       = cma_decode(lat_addr_reg);
    state_next    = state_reg;
    lat_addr_next = lat_addr_reg;
    lat_data_next = lat_data_reg;
    busy_next     = busy_reg;
    done_next     = 1'b0;
    reject_next   = 1'b0;
    timer_start   = 1'b0;
    case (state_reg)
      cma_pkg::CMA_IDLE, cma_pkg::CMA_LOADED: begin
        if (table_write_instr_in && table_pointer_in >= cma_pkg::CFG_SPACE_BASE) begin
          lat_addr_next = table_pointer_in; // [R5]
          lat_data_next = table_write_data_in; // [R7]
          state_next    = cma_pkg::CMA_LOADED;
        end
        if (nv_write_start_in) begin
          if (state_reg == cma_pkg::CMA_LOADED) begin
            timer_start = 1'b1; // [R4]
            busy_next   = 1'b1;
            state_next  = cma_pkg::CMA_PROG;
          end else begin
            reject_next = 1'b1;
          end
        end
      end
      cma_pkg::CMA_PROG: begin
        if (nv_write_start_in) begin
          reject_next = 1'b1;
        end
        if (timer_done) begin
          state_next = cma_pkg::CMA_COMMIT; // [R4]
        end
      end
      cma_pkg::CMA_COMMIT: begin
        busy_next  = 1'b0;
        done_next  = 1'b1;
        state_next = cma_pkg::CMA_IDLE;
      end
      default: begin
        state_next = cma_pkg::CMA_IDLE;
        busy_next  = 1'b0;
      end
    endcase
  end

  // Commit data with protected fields held outside high-voltage programming mode
  always_comb begin
    commit_vec  = '0;
    commit_data = lat_data_reg;
    if (!hv_prog_mode_in && lat_dec.idx == cma_pkg::IDX_DEBUG_PROGRAMMING_CONFIG) begin
      commit_data[cma_pkg::LOW_VOLTAGE_PROG_ENABLE_BIT] =
        cell_value[cma_pkg::IDX_DEBUG_PROGRAMMING_CONFIG][cma_pkg::LOW_VOLTAGE_PROG_ENABLE_BIT]; // [R9]
    end
    if (!hv_prog_mode_in && lat_dec.idx == cma_pkg::IDX_WRITE_PROTECT_SPECIAL) begin
      commit_data[cma_pkg::CONFIG_WRITE_PROTECT_BIT] =
        cell_value[cma_pkg::IDX_WRITE_PROTECT_SPECIAL][cma_pkg::CONFIG_WRITE_PROTECT_BIT]; // [R10]
    end
    if (state_reg == cma_pkg::CMA_COMMIT && lat_dec.hit && !lat_dec.ident) begin
      commit_vec[lat_dec.idx] = 1'b1; // [R6] [R8]
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_reg    <= cma_pkg::CMA_IDLE;
      lat_addr_reg <= 22'h000000;
      lat_data_reg <= 8'hFF;
      busy_reg     <= 1'b0;
      done_reg     <= 1'b0;
      reject_reg   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      lat_addr_reg <= lat_addr_next;
      lat_data_reg <= lat_data_next;
      busy_reg     <= busy_next;
      done_reg     <= done_next;
      reject_reg   <= reject_next;
    end
  end

  // Table read path
  logic [7:0]  rd_data_reg;
  logic [7:0]  rd_data_next;
  logic        rd_valid_reg;
  logic        rd_valid_next;
  cma_decode_t rd_dec;

  always_comb begin
    rd_dec        = cma_decode(table_pointer_in);
    rd_data_next  = rd_data_reg;
    rd_valid_next = 1'b0;
    if (table_read_instr_in) begin
      rd_valid_next = 1'b1;
      rd_data_next  = 8'h00;
      if (rd_dec.hit) begin
        rd_data_next = cell_value[rd_dec.idx]; // [R15]
      end else if (table_pointer_in == cma_pkg::OFS_PART_REVISION_IDENT) begin
        rd_data_next = {IDENT_PART[2:0], IDENT_REVISION}; // [R14]
      end else if (table_pointer_in == cma_pkg::OFS_PART_IDENT_HIGH) begin
        rd_data_next = IDENT_PART[10:3]; // [R14]
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rd_data_reg  <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // Ordinary accesses into configuration space are refused
  logic fault_reg;
  logic fault_next;

  always_comb begin
    fault_next = ordinary_access_in && (ordinary_addr_in >= cma_pkg::CFG_SPACE_BASE); // [R3]
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= fault_next;
    end
  end

  // Decoded configuration outputs
  logic [1:0] wdt_en;
  logic       wdt_hw_reg;
  logic       wdt_hw_next;
  logic       wdt_sw_reg;
  logic       wdt_sw_next;
  logic       wdt_act_reg;
  logic       wdt_act_next;
  logic       lvp_reg;
  logic       lvp_next;
  logic       dbg_reg;
  logic       dbg_next;
  logic       wprot_reg;
  logic       wprot_next;

  always_comb begin
    wdt_en       = cell_value[cma_pkg::IDX_WATCHDOG_CONFIG][cma_pkg::WATCHDOG_EN_LSB +: 2];
    wdt_hw_next  = (wdt_en == cma_pkg::WDT_EN_HW_ALWAYS); // [R12]
    wdt_sw_next  = (wdt_en == cma_pkg::WDT_EN_SOFTWARE); // [R12]
    wdt_act_next = (wdt_en == cma_pkg::WDT_EN_ACTIVE);
    lvp_next     = cell_value[cma_pkg::IDX_DEBUG_PROGRAMMING_CONFIG][cma_pkg::LOW_VOLTAGE_PROG_ENABLE_BIT];
    dbg_next     = cell_value[cma_pkg::IDX_DEBUG_PROGRAMMING_CONFIG][cma_pkg::DEDICATED_DEBUG_PORT_BIT];
    wprot_next   = cell_value[cma_pkg::IDX_WRITE_PROTECT_SPECIAL][cma_pkg::CONFIG_WRITE_PROTECT_BIT];
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wdt_hw_reg  <= 1'b1;
      wdt_sw_reg  <= 1'b0;
      wdt_act_reg <= 1'b0;
      lvp_reg     <= 1'b1;
      dbg_reg     <= 1'b1;
      wprot_reg   <= 1'b1;
    end else begin
      wdt_hw_reg  <= wdt_hw_next;
      wdt_sw_reg  <= wdt_sw_next;
      wdt_act_reg <= wdt_act_next;
      lvp_reg     <= lvp_next;
      dbg_reg     <= dbg_next;
      wprot_reg   <= wprot_next;
    end
  end

  // Output drive
  assign table_read_data_out             = rd_data_reg;
  assign table_read_valid_out            = rd_valid_reg;
  assign nv_write_busy_out               = busy_reg;
  assign nv_write_done_out               = done_reg;
  assign nv_write_rejected_out           = reject_reg;
  assign access_fault_out                = fault_reg;
  assign watchdog_timer_hw_enable_out    = wdt_hw_reg;
  assign watchdog_timer_sw_control_out   = wdt_sw_reg;
  assign watchdog_timer_active_only_out  = wdt_act_reg;
  assign low_voltage_prog_enable_out     = lvp_reg;
  assign dedicated_debug_port_enable_out = dbg_reg;
  assign config_write_protect_out        = wprot_reg;

endmodule // cma_top

//--- common/cma_pkg.sv
// Purpose: Shared constants and types for the configuration memory access block.
// Assumes: 22-bit table pointer, byte-wide configuration cells, 10 MHz core clock.
// Notes:   Default and mask tables are indexed by configuration byte number.
package cma_pkg;

  // Address space
  localparam int          ADDR_W          = 22;
  localparam int          DATA_W          = 8;
  localparam logic [21:0] CFG_SPACE_BASE  = 22'h300000;
  localparam logic [21:0] CFG_SPACE_END   = 22'h3FFFFF;
  localparam int          NUM_CFG_BYTES   = 14;
  localparam int          IDX_W           = 4;

  // Configuration byte offsets
  localparam logic [21:0] OFS_CLOCK_DIVIDER_PLL_CONFIG  = 22'h300000;
  localparam logic [21:0] OFS_OSCILLATOR_SELECT_CONFIG  = 22'h300001;
  localparam logic [21:0] OFS_BROWNOUT_POWERUP_CONFIG   = 22'h300002;
  localparam logic [21:0] OFS_WATCHDOG_CONFIG           = 22'h300003;
  localparam logic [21:0] OFS_SPARE_CONFIG_THREE_LOW    = 22'h300004;
  localparam logic [21:0] OFS_PIN_ROUTING_CONFIG        = 22'h300005;
  localparam logic [21:0] OFS_DEBUG_PROGRAMMING_CONFIG  = 22'h300006;
  localparam logic [21:0] OFS_SPARE_CONFIG_FOUR_HIGH    = 22'h300007;
  localparam logic [21:0] OFS_CODE_PROTECT_BLOCKS       = 22'h300008;
  localparam logic [21:0] OFS_CODE_PROTECT_BOOT_DATA    = 22'h300009;
  localparam logic [21:0] OFS_WRITE_PROTECT_BLOCKS      = 22'h30000A;
  localparam logic [21:0] OFS_WRITE_PROTECT_SPECIAL     = 22'h30000B;
  localparam logic [21:0] OFS_TABLE_READ_PROTECT_BLOCKS = 22'h30000C;
  localparam logic [21:0] OFS_TABLE_READ_PROTECT_BOOT   = 22'h30000D;
  localparam logic [21:0] OFS_PART_REVISION_IDENT       = 22'h3FFFFE;
  localparam logic [21:0] OFS_PART_IDENT_HIGH           = 22'h3FFFFF;

  // Byte indices used by decoded and restricted fields
  localparam logic [3:0]  IDX_WATCHDOG_CONFIG          = 4'h3;
  localparam logic [3:0]  IDX_DEBUG_PROGRAMMING_CONFIG = 4'h6;
  localparam logic [3:0]  IDX_WRITE_PROTECT_SPECIAL    = 4'hB;

  // Field positions
  localparam int          LOW_VOLTAGE_PROG_ENABLE_BIT  = 2;
  localparam int          DEDICATED_DEBUG_PORT_BIT     = 5;
  localparam int          CONFIG_WRITE_PROTECT_BIT     = 5;
  localparam int          WATCHDOG_EN_LSB              = 0;
  localparam int          REV_FIELD_W                  = 5;
  localparam int          PART_FIELD_W                 = 11;

  // Watchdog enable encodings
  localparam logic [1:0]  WDT_EN_HW_ALWAYS  = 2'h3;
  localparam logic [1:0]  WDT_EN_SOFTWARE   = 2'h2;
  localparam logic [1:0]  WDT_EN_ACTIVE     = 2'h1;
  localparam logic [1:0]  WDT_EN_OFF        = 2'h0;

  // Unprogrammed values and implemented-bit masks, byte 0 first
  localparam logic [7:0] CFG_DEFAULT [NUM_CFG_BYTES] = '{
    8'h00, 8'h25, 8'h5F, 8'h3F, 8'h00, 8'hD3, 8'hA5,
    8'hFF, 8'h0F, 8'hC0, 8'h0F, 8'hE0, 8'h0F, 8'h40};
  localparam logic [7:0] CFG_IMPL_MASK [NUM_CFG_BYTES] = '{
    8'h3B, 8'hEF, 8'h5F, 8'h3F, 8'h00, 8'hD3, 8'hE5,
    8'h00, 8'h0F, 8'hC0, 8'h0F, 8'hE0, 8'h0F, 8'h40};

  // Identification codes, values arbitrary
  localparam logic [4:0]  IDENT_REVISION_DEFAULT = 5'h01;
  localparam logic [10:0] IDENT_PART_DEFAULT     = 11'h2A5;

  // Self-timed write length
  localparam int          PROG_TIME_US  = 1000;
  localparam int          CLK_FREQ_MHZ  = 10;
  localparam int          PROG_CYCLES   = PROG_TIME_US * CLK_FREQ_MHZ;

  typedef enum logic [3:0] {
    CMA_IDLE   = 4'h1,
    CMA_LOADED = 4'h2,
    CMA_PROG   = 4'h4,
    CMA_COMMIT = 4'h8
  } cma_state_t;

endpackage : cma_pkg

//--- core/cma_cfg_byte.sv
// Purpose: One nonvolatile configuration byte cell.
// Assumes: Commit strobe comes only at the end of a completed self-timed write.
// Notes:   Unimplemented positions always show the unprogrammed value.
module cma_cfg_byte #(
  parameter logic [7:0] DEFAULT_VALUE = 8'hFF,
  parameter logic [7:0] IMPL_MASK     = 8'hFF
) (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  // Commit
  input  wire logic       commit_in,
  input  wire logic [7:0] commit_data_in,
  // Contents
  output logic      [7:0] value_out
);

  logic [7:0] value_reg;
  logic [7:0] value_next;

  always_comb begin
    value_next = value_reg;
    if (commit_in) begin
      value_next = (commit_data_in & IMPL_MASK) | (DEFAULT_VALUE & ~IMPL_MASK);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      value_reg <= DEFAULT_VALUE;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value_out = value_reg;

endmodule // cma_cfg_byte

//--- core/cma_prog_timer.sv
// Purpose: Self-timed programming interval counter.
// Assumes: start_in is ignored while a count is running.
// Notes:   done_out pulses for one cycle as the count expires.
module cma_prog_timer #(
  parameter int CYCLES = 10000
) (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  // Control
  input  wire logic start_in,
  // Status
  output logic      busy_out,
  output logic      done_out
);

  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic             busy_reg;
  logic             busy_next;
  logic             done_reg;
  logic             done_next;

  always_comb begin
    count_next = count_reg;
    busy_next  = busy_reg;
    done_next  = 1'b0;
    if (busy_reg) begin
      if (count_reg == LAST) begin
        busy_next  = 1'b0;
        done_next  = 1'b1;
        count_next = '0;
      end else begin
        count_next = count_reg + CNT_W'(1);
      end
    end else if (start_in) begin
      busy_next  = 1'b1;
      count_next = '0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      count_reg <= '0;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      busy_reg  <= busy_next;
      done_reg  <= done_next;
    end
  end

  assign busy_out = busy_reg;
  assign done_out = done_reg;

endmodule // cma_prog_timer

//--- bench/cma_core_model.sv
// Purpose: Core-side model issuing table reads, table writes, write starts and ordinary accesses.
// Assumes: Requests change 1 ns after an edge and last one cycle.
// Notes:   Between requests the pointer and data show inverted values.
module cma_core_model (
  // Clock
  input  wire logic        core_clk_in,
  // Table access
  output logic      [21:0] table_pointer_out,
  output logic             table_read_instr_out,
  output logic             table_write_instr_out,
  output logic      [7:0]  table_write_data_out,
  input  wire logic [7:0]  table_read_data_in,
  // Control and ordinary access
  output logic             nv_write_start_out,
  output logic             ordinary_access_out,
  output logic      [21:0] ordinary_addr_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial {table_pointer_out, table_read_instr_out, table_write_instr_out, table_write_data_out,
           nv_write_start_out, ordinary_access_out, ordinary_addr_out} = '0;

  task automatic pulse(input logic [21:0] addr, input logic rd, input logic wr, input logic [7:0] data);
    @(posedge core_clk_in);
    #1;
    table_pointer_out     = addr;
    table_read_instr_out  = rd;
    table_write_instr_out = wr;
    table_write_data_out  = data;
    @(posedge core_clk_in);
    #1;
    table_read_instr_out  = 1'b0;
    table_write_instr_out = 1'b0;
    table_pointer_out     = ~addr;
    table_write_data_out  = ~data;
  endtask

  task automatic tbl_read(input logic [21:0] addr, output logic [7:0] data);
    pulse(addr, 1'b1, 1'b0, 8'h00);
    data = table_read_data_in;
  endtask

  task automatic start_bit();
    nv_write_start_out = 1'b1;
    @(posedge core_clk_in);
    #1;
    nv_write_start_out = 1'b0;
  endtask

  // Address and data loaded before the start bit
  task automatic cfg_write(input logic [21:0] addr, input logic [7:0] data);
    pulse(addr, 1'b0, 1'b1, data);
    start_bit();
  endtask

  task automatic ordinary(input logic [21:0] addr);
    @(posedge core_clk_in);
    #1;
    ordinary_access_out = 1'b1;
    ordinary_addr_out   = addr;
    @(posedge core_clk_in);
    #1;
    ordinary_access_out = 1'b0;
    ordinary_addr_out   = ~addr;
  endtask
endmodule  // cma_core_model

//--- bench/cma_checker.sv
// Purpose: Port-level assertions for the configuration memory access block.
// Assumes: Sees only the top's ports.
// Notes:   Busy length is counted in helper logic.
module cma_checker #(
  parameter int          PROG_CYCLES = 8,
  parameter logic [10:0] IDENT_PART  = 11'h000
) (
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic [21:0] table_pointer_in,
  input wire logic        table_read_instr_in,
  input wire logic [7:0]  table_read_data_out,
  input wire logic        table_read_valid_out,
  input wire logic        nv_write_busy_out,
  input wire logic        nv_write_done_out,
  input wire logic        nv_write_rejected_out,
  input wire logic        ordinary_access_in,
  input wire logic [21:0] ordinary_addr_in,
  input wire logic        access_fault_out,
  input wire logic        hv_prog_mode_in,
  input wire logic        watchdog_timer_hw_enable_out,
  input wire logic        watchdog_timer_sw_control_out,
  input wire logic        watchdog_timer_active_only_out,
  input wire logic        low_voltage_prog_enable_out,
  input wire logic        config_write_protect_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] busy_cnt_reg;
  logic [7:0] busy_cnt_next;

  always_comb begin
    busy_cnt_next = nv_write_busy_out ? busy_cnt_reg + 8'h01 : 8'h00;
  end
  always_ff @(posedge core_clk_in) begin
    busy_cnt_reg <= rst_in ? 8'h00 : busy_cnt_next;
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  a_read_answer: assert property (table_read_instr_in |=> table_read_valid_out)
    else $error("table read not answered");
  a_unmapped_zero: assert property (table_read_instr_in && !(table_pointer_in inside
    {[22'h300000:22'h30000D], [22'h3FFFFE:22'h3FFFFF]}) |=> table_read_data_out == 8'h00)
    else $error("unmapped read not zero");
  a_ident_part: assert property (table_read_instr_in && table_pointer_in == 22'h3FFFFF
    |=> table_read_data_out == IDENT_PART[10:3]) else $error("part code wrong");
  a_fault_answer: assert property (ordinary_access_in && ordinary_addr_in >= 22'h300000 |=> access_fault_out)
    else $error("ordinary access not refused");
  a_no_false_fault: assert property (access_fault_out |-> $past(ordinary_access_in)
    && $past(ordinary_addr_in) >= 22'h300000) else $error("fault without cause");
  a_busy_length: assert property ($fell(nv_write_busy_out) |-> busy_cnt_reg == 8'(PROG_CYCLES + 2))
    else $error("busy length wrong");
  a_done_busy_fall: assert property (nv_write_done_out |-> $fell(nv_write_busy_out))
    else $error("done apart from busy fall");
  a_low_volt_guard: assert property ($changed(low_voltage_prog_enable_out)
    |-> $past(nv_write_done_out) && $past(hv_prog_mode_in, 2)) else $error("low voltage bit changed");
  a_protect_guard: assert property ($changed(config_write_protect_out)
    |-> $past(nv_write_done_out) && $past(hv_prog_mode_in, 2)) else $error("protect bit changed");
  a_watchdog_decode: assert property ($onehot0({watchdog_timer_hw_enable_out,
    watchdog_timer_sw_control_out, watchdog_timer_active_only_out})) else $error("watchdog decode");

  c_prog_done: cover property (nv_write_done_out);
  c_rejected: cover property (nv_write_rejected_out);
  c_fault: cover property (access_fault_out);
endmodule  // cma_checker

//--- bench/config_memory_access_test.sv
// Purpose: Self-checking bench for the configuration memory access block.
// Assumes: Shortened programming interval.
// Notes:   Identification values are arbitrary.
module config_memory_access_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int          PROG_CYCLES = 8;
  localparam logic [4:0]  ID_REVISION = 5'h0A;    // Arbitrary
  localparam logic [10:0] ID_PART     = 11'h155;  // Arbitrary
  logic        core_clk_in;
  logic        rst_in;
  logic        hv_prog_mode_in;
  logic [21:0] table_pointer_in;
  logic [21:0] ordinary_addr_in;
  logic [7:0]  table_write_data_in;
  logic [7:0]  table_read_data_out;
  logic        table_read_instr_in, table_write_instr_in, table_read_valid_out, nv_write_start_in;
  logic        nv_write_busy_out, nv_write_done_out, nv_write_rejected_out, ordinary_access_in;
  logic        access_fault_out, watchdog_timer_hw_enable_out, watchdog_timer_sw_control_out;
  logic        watchdog_timer_active_only_out, low_voltage_prog_enable_out;
  logic        dedicated_debug_port_enable_out, config_write_protect_out;
  int          failures;
  int          samples_checked;
  int          n;
  logic [7:0]  rd;

  cma_top #(.PROG_CYCLES(PROG_CYCLES), .IDENT_REVISION(ID_REVISION), .IDENT_PART(ID_PART)) i_cma_top (.*);

  cma_core_model i_cma_core_model (
    .core_clk_in, .table_pointer_out(table_pointer_in), .table_read_instr_out(table_read_instr_in),
    .table_write_instr_out(table_write_instr_in), .table_write_data_out(table_write_data_in),
    .table_read_data_in(table_read_data_out), .nv_write_start_out(nv_write_start_in),
    .ordinary_access_out(ordinary_access_in), .ordinary_addr_out(ordinary_addr_in));

  initial core_clk_in = 1'b0;
  always #50 core_clk_in = ~core_clk_in;

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic read_check(input logic [21:0] addr, input logic [7:0] exp);
    i_cma_core_model.tbl_read(addr, rd);
    check_byte(rd, exp);
  endtask
  task automatic wait_done();
    n = 0;
    while (nv_write_done_out !== 1'b1 && n < 40) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    check_bit(nv_write_done_out, 1'b1);
    @(posedge core_clk_in);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic t_defaults();
    for (int i = 0; i < cma_pkg::NUM_CFG_BYTES; i++) begin
      read_check(cma_pkg::CFG_SPACE_BASE + 22'(i), cma_pkg::CFG_DEFAULT[i]);
    end
    read_check(22'h30000E, 8'h00);
    read_check(22'h2FFFFF, 8'h00);
    read_check(22'h3FFFFE, {ID_PART[2:0], ID_REVISION});
    read_check(22'h3FFFFF, ID_PART[10:3]);
    check_bit(watchdog_timer_hw_enable_out, 1'b1);
    check_bit(dedicated_debug_port_enable_out, 1'b1);
    $display("test defaults done");
  endtask
  task automatic t_watchdog();
    i_cma_core_model.cfg_write(22'h300003, 8'h3E);
    check_bit(nv_write_busy_out, 1'b1);
    read_check(22'h300003, 8'h3F);
    read_check(22'h300002, 8'h5F);
    wait_done();
    check_bit(watchdog_timer_sw_control_out, 1'b1);
    check_bit(watchdog_timer_hw_enable_out, 1'b0);
    read_check(22'h300003, 8'h3E);
    $display("test watchdog done");
  endtask
  task automatic t_ident();
    i_cma_core_model.cfg_write(22'h3FFFFF, 8'h00);
    wait_done();
    check_byte(8'(n), 8'(PROG_CYCLES + 2));
    read_check(22'h3FFFFF, ID_PART[10:3]);
    $display("test ident done");
  endtask
  task automatic t_restrict();
    i_cma_core_model.cfg_write(22'h300006, 8'h81);
    wait_done();
    check_bit(low_voltage_prog_enable_out, 1'b1);
    check_bit(dedicated_debug_port_enable_out, 1'b0);
    read_check(22'h300006, 8'h85);
    i_cma_core_model.cfg_write(22'h30000B, 8'hC0);
    wait_done();
    check_bit(config_write_protect_out, 1'b1);
    read_check(22'h30000B, 8'hE0);
    hv_prog_mode_in = 1'b1;
    i_cma_core_model.cfg_write(22'h30000B, 8'hC0);
    wait_done();
    check_bit(config_write_protect_out, 1'b0);
    i_cma_core_model.cfg_write(22'h300006, 8'h81);
    wait_done();
    check_bit(low_voltage_prog_enable_out, 1'b0);
    read_check(22'h300006, 8'h81);
    hv_prog_mode_in = 1'b0;
    $display("test restrict done");
  endtask
  task automatic t_reject();
    i_cma_core_model.start_bit();
    check_bit(nv_write_rejected_out, 1'b1);
    i_cma_core_model.cfg_write(22'h300000, 8'h18);
    i_cma_core_model.pulse(22'h300001, 1'b0, 1'b1, 8'h00);
    i_cma_core_model.start_bit();
    check_bit(nv_write_rejected_out, 1'b1);
    wait_done();
    read_check(22'h300000, 8'h18);
    read_check(22'h300001, 8'h25);
    i_cma_core_model.ordinary(22'h300000);
    check_bit(access_fault_out, 1'b1);
    i_cma_core_model.ordinary(22'h0000FF);
    check_bit(access_fault_out, 1'b0);
    $display("test reject done");
  endtask

  initial begin
    failures        = 0;
    samples_checked = 0;
    hv_prog_mode_in = 1'b0;
    rst_in          = 1'b1;
    repeat (8) @(posedge core_clk_in);
    #1;
    rst_in = 1'b0;
    t_defaults();
    t_watchdog();
    t_ident();
    t_restrict();
    t_reject();
    print_verdict();
  end

  initial begin
    repeat (3000) @(posedge core_clk_in);
    failures++;
    $display("unexpected at %0t: run timed out", $time);
    print_verdict();
  end
endmodule  // config_memory_access_test

bind cma_top cma_checker #(.PROG_CYCLES(PROG_CYCLES), .IDENT_PART(IDENT_PART)) i_cma_checker (.*);
